// ---- shared/ascfr_map.svh ----
// register indices, field positions and reset values of the setup bank
`ifndef ASCFR_MAP_SVH
`define ASCFR_MAP_SVH
`define ASCFR_IDX_OFFSET0  10'h029
`define ASCFR_IDX_OFFSET7  10'h030
`define ASCFR_IDX_GAIN0    10'h031
`define ASCFR_IDX_GAIN7    10'h038
`define ASCFR_IDX_FILTER0  10'h040
`define ASCFR_IDX_FILTER7  10'h047
`define ASCFR_MODE_HI      15
`define ASCFR_MODE_LO      12
`define ASCFR_RATE_HI      10
`define ASCFR_RATE_LO      0
`define ASCFR_MODE_RESET   4'h2
`define ASCFR_MODE_LAST    4'h8
`define ASCFR_RATE_RESET   11'h030
`define ASCFR_RATE_ZERO    11'h000
`define ASCFR_RATE_ONE     11'h001
`define ASCFR_OFFSET_RESET 24'h800000
`define ASCFR_GAIN_NOMINAL 24'h555555
`endif

// ---- shared/ascfr_pkg.sv ----
// types of the setup, filter and calibration register bank
package ascfr_pkg;
  // filter type codes of one setup
  typedef enum logic [3:0] {
    ASCFR_SINC4       = 4'h0,
    ASCFR_SINC4_AVG   = 4'h1,
    ASCFR_SINC3       = 4'h2,
    ASCFR_SINC3_NOTCH = 4'h3,
    ASCFR_SINC3_AVG   = 4'h4,
    ASCFR_SINC3_POST1 = 4'h5,
    ASCFR_SINC3_POST2 = 4'h6,
    ASCFR_SINC3_POST3 = 4'h7,
    ASCFR_SINC3_POST4 = 4'h8
  } ascfr_mode_t;
  // one setup's filter configuration
  typedef struct packed {
    logic [3:0]  mode;
    logic [10:0] rate;
  } ascfr_filt_t;
  // decoded filter steering for the active setup
  typedef struct packed {
    logic        sinc4;
    logic        averaging;
    logic        extra_notch_sixfifths;
    logic [2:0]  post_filter;
    logic        fixed_rate;
    logic [10:0] rate_divider_value;
    logic [23:0] offset;
    logic [23:0] gain;
  } ascfr_fout_t;
  // calibration result from the conversion core
  typedef struct packed {
    logic        done;
    logic        is_gain;
    logic [2:0]  setup;
    logic [23:0] result;
  } ascfr_cal_t;
  // trim load sequencing
  typedef enum logic [1:0] {
    ASCFR_ST_TRIM = 2'b01,
    ASCFR_ST_RUN  = 2'b10
  } ascfr_st_t;
  // whole state of the bank
  typedef struct packed {
    ascfr_st_t              st;
    ascfr_filt_t [7:0]      filt;
    logic [7:0][23:0]       offset;
    logic [7:0][23:0]       gain;
    ascfr_fout_t            fout;
    logic [31:0]            prdata;
  } ascfr_state_t;
endpackage

// ---- rtl/ascfr_regs.sv ----
// setup filter and calibration coefficient register bank with APB slave
`timescale 1ns/1ps
`include "ascfr_map.svh"
module ascfr_regs (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  // apb slave
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [11:0]          paddr_in,
  input  wire logic [31:0]          pwdata_in,
  input  wire logic [3:0]           pstrb_in,
  output logic [31:0]               prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  // conversion core side
  input  wire logic [2:0]           active_setup_in,
  input  wire ascfr_pkg::ascfr_cal_t cal_in,
  input  wire logic [23:0]          trim_gain_in,
  output ascfr_pkg::ascfr_fout_t    fout_out
);

  // reset release through two flops
  logic [1:0]             rst_sync;
  logic                   rst_n;
  ascfr_pkg::ascfr_state_t s;       // registered state
  ascfr_pkg::ascfr_state_t next_s;  // next state
  logic [9:0]             idx;      // word index of paddr
  logic                   setup_ph; // apb setup phase
  logic                   wr_acc;   // apb write takes effect

  // merge byte lanes of a write into an old 24-bit value
  function automatic logic [23:0] merge24(input logic [23:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
    logic [23:0] r;
    r = old_v;
    for (int b = 0; b < 3; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // decode a word index: 0 none, 1 offset, 2 gain, 3 filter
  function automatic logic [1:0] kind_of(input logic [9:0] i);
    if (i >= `ASCFR_IDX_OFFSET0 && i <= `ASCFR_IDX_OFFSET7) begin
      return 2'h1;
    end else if (i >= `ASCFR_IDX_GAIN0 && i <= `ASCFR_IDX_GAIN7) begin
      return 2'h2;
    end else if (i >= `ASCFR_IDX_FILTER0 && i <= `ASCFR_IDX_FILTER7) begin
      return 2'h3;
    end else begin
      return 2'h0;
    end
  endfunction

  // rate divider as the filter uses it
  function automatic logic [10:0] eff_rate(input logic [10:0] r);
    return (r == `ASCFR_RATE_ZERO) ? `ASCFR_RATE_ONE : r;
  endfunction

  // filter register as read back; bits above the rate field
  // other than the mode read zero
  function automatic logic [31:0] filt_word(
      input ascfr_pkg::ascfr_filt_t f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`ASCFR_MODE_HI:`ASCFR_MODE_LO] = f.mode;
    w[`ASCFR_RATE_HI:`ASCFR_RATE_LO] = f.rate;
    return w;
  endfunction

  // reset release: asserts at once, releases after two edges
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // bus phase decode
  assign idx      = paddr_in[11:2];
  assign setup_ph = psel_in && !penable_in;
  assign wr_acc   = psel_in && penable_in && pwrite_in &&
                    kind_of(idx) != 2'h0 && paddr_in[1:0] == 2'b00;

  // zero-wait slave: every access ends in one access cycle
  assign pready_out  = 1'b1;
  // unmapped or misaligned words answer with an error
  assign pslverr_out = psel_in && penable_in &&
                       (kind_of(idx) == 2'h0 || paddr_in[1:0] != 2'b00);
  assign prdata_out  = s.prdata;
  assign fout_out    = s.fout;

  // next-state logic of the whole bank
  always_comb begin
    logic [2:0]             n;
    logic [23:0]            fw;
    logic [31:0]            fo;
    ascfr_pkg::ascfr_filt_t fa;
    // both coefficient ranges start one above a multiple of eight, so
    // the low index bits minus one give the setup: 29h->0 ... 30h->7
    // and 31h->0 ... 38h->7
    n      = idx[2:0] - 3'h1;
    fw     = 24'h000000;
    fo     = 32'h0000_0000;
    fa     = s.filt[active_setup_in];
    next_s = s;
    // read data is caught in the setup phase so it stands for access
    if (setup_ph) begin
      next_s.prdata = 32'h0000_0000;
      if (kind_of(idx) == 2'h1 && paddr_in[1:0] == 2'b00) begin
        next_s.prdata = {8'h00, s.offset[n]};
      end else if (kind_of(idx) == 2'h2 && paddr_in[1:0] == 2'b00) begin
        next_s.prdata = {8'h00, s.gain[n]};
      end else if (kind_of(idx) == 2'h3 && paddr_in[1:0] == 2'b00) begin
        next_s.prdata = filt_word(s.filt[idx[2:0]]);
      end
    end
    // host writes to coefficients and filter setups
    if (wr_acc) begin
      if (kind_of(idx) == 2'h1) begin
        next_s.offset[n] = merge24(s.offset[n], pwdata_in,
                                   pstrb_in);
      end else if (kind_of(idx) == 2'h2) begin
        // gain words use the same offset-by-one index as offsets
        next_s.gain[n] = merge24(s.gain[n], pwdata_in,
                                 pstrb_in);
      end else begin
        // only the low two lanes of the filter word are stored
        fo = filt_word(s.filt[idx[2:0]]);
        fw = merge24(fo[23:0], pwdata_in, pstrb_in);
        // reserved codes 1001-1111 are refused; the mode stays
        if (fw[`ASCFR_MODE_HI:`ASCFR_MODE_LO] <= `ASCFR_MODE_LAST) begin
          next_s.filt[idx[2:0]].mode =
            fw[`ASCFR_MODE_HI:`ASCFR_MODE_LO];
        end
        next_s.filt[idx[2:0]].rate =
          fw[`ASCFR_RATE_HI:`ASCFR_RATE_LO];
      end
    end
    // calibration result lands after host writes so it wins over them; the trim load comes later still
    if (cal_in.done) begin
      if (cal_in.is_gain) begin
        next_s.gain[cal_in.setup] = cal_in.result;
      end else begin
        next_s.offset[cal_in.setup] = cal_in.result;
      end
    end
    // one-shot trim load after reset release
    case (s.st)
      ascfr_pkg::ASCFR_ST_TRIM: begin
        for (int k = 0; k < 8; k++) begin
          next_s.gain[k] = trim_gain_in;
        end
        next_s.st = ascfr_pkg::ASCFR_ST_RUN;
      end
      ascfr_pkg::ASCFR_ST_RUN: begin
        next_s.st = ascfr_pkg::ASCFR_ST_RUN;
      end
      default: begin
        next_s.st = ascfr_pkg::ASCFR_ST_TRIM;
      end
    endcase
    // steering of the filter for the active setup
    next_s.fout.offset = s.offset[active_setup_in];
    next_s.fout.gain   = s.gain[active_setup_in];
    next_s.fout.rate_divider_value = eff_rate(fa.rate);
    next_s.fout.sinc4       = 1'b0;
    next_s.fout.averaging   = 1'b0;
    next_s.fout.extra_notch_sixfifths = 1'b0;
    next_s.fout.post_filter = 3'h0;
    next_s.fout.fixed_rate  = 1'b0;
    case (fa.mode)
      ascfr_pkg::ASCFR_SINC4: begin
        next_s.fout.sinc4 = 1'b1;
      end
      ascfr_pkg::ASCFR_SINC4_AVG: begin
        next_s.fout.sinc4     = 1'b1;
        next_s.fout.averaging = 1'b1;
      end
      ascfr_pkg::ASCFR_SINC3: begin
        next_s.fout.sinc4 = 1'b0;
      end
      ascfr_pkg::ASCFR_SINC3_NOTCH: begin
        // with rate 48 the notches fall on 50 and 60 Hz
        next_s.fout.extra_notch_sixfifths = 1'b1;
      end
      ascfr_pkg::ASCFR_SINC3_AVG: begin
        next_s.fout.averaging = 1'b1;
      end
      ascfr_pkg::ASCFR_SINC3_POST1: begin
        next_s.fout.post_filter = 3'h1;
        next_s.fout.fixed_rate  = 1'b1;
      end
      ascfr_pkg::ASCFR_SINC3_POST2: begin
        next_s.fout.post_filter = 3'h2;
        next_s.fout.fixed_rate  = 1'b1;
      end
      ascfr_pkg::ASCFR_SINC3_POST3: begin
        next_s.fout.post_filter = 3'h3;
        next_s.fout.fixed_rate  = 1'b1;
      end
      ascfr_pkg::ASCFR_SINC3_POST4: begin
        next_s.fout.post_filter = 3'h4;
        next_s.fout.fixed_rate  = 1'b1;
      end
      default: begin
        next_s.fout.post_filter = 3'h0;
      end
    endcase
  end

  // state register; gains start nominal until the trim lands
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s.st     <= ascfr_pkg::ASCFR_ST_TRIM;
      s.prdata <= 32'h0000_0000;
      s.fout   <= '0;
      for (int k = 0; k < 8; k++) begin
        s.filt[k].mode <= `ASCFR_MODE_RESET;
        s.filt[k].rate <= `ASCFR_RATE_RESET;
        s.offset[k]    <= `ASCFR_OFFSET_RESET;
        s.gain[k]      <= `ASCFR_GAIN_NOMINAL;
      end
    end else begin
      s <= next_s;
    end
  end

  // checks next to the logic
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  AST_MODE_RESET: assert property (
    $rose(rst_n) |-> s.filt[0].mode == `ASCFR_MODE_RESET &&
                     s.filt[7].mode == `ASCFR_MODE_RESET)
    else $error("filter mode not at reset code");
  AST_SINC3_ALONE: assert property (
    s.filt[active_setup_in].mode == 4'h2 && $stable(active_setup_in)
    |=> !fout_out.sinc4 && !fout_out.averaging &&
        !fout_out.extra_notch_sixfifths && fout_out.post_filter == 3'h0)
    else $error("sinc3 alone mode drives extra stages");
  // no code but 0011 may raise the extra notch
  AST_NOTCH: assert property (
    s.filt[active_setup_in].mode != 4'h3
    |=> !fout_out.extra_notch_sixfifths)
    else $error("notch without its code");
  AST_NOTCH_48: assert property (
    s.filt[active_setup_in].mode == 4'h3 &&
    s.filt[active_setup_in].rate == 11'h030
    |=> fout_out.extra_notch_sixfifths &&
        fout_out.rate_divider_value == 11'h030)
    else $error("50/60 Hz setting not steered");
  AST_AVG3: assert property (
    s.filt[active_setup_in].mode == 4'h4
    |=> fout_out.averaging && !fout_out.sinc4)
    else $error("sinc3 averaging not steered");
  AST_POST: assert property (
    s.filt[active_setup_in].mode >= 4'h5 &&
    s.filt[active_setup_in].mode <= 4'h8
    |=> fout_out.fixed_rate && fout_out.post_filter ==
        3'($past(s.filt[active_setup_in].mode) - 4'h4))
    else $error("post filter index wrong");
  AST_RATE_ZERO: assert property (
    s.filt[active_setup_in].rate == 11'h000
    |=> fout_out.rate_divider_value == 11'h001)
    else $error("rate zero not treated as one");
  AST_OFFSET_RESET: assert property (
    $rose(rst_n) |-> s.offset[0] == 24'h800000 &&
                     s.offset[7] == 24'h800000)
    else $error("offset reset value wrong");
  AST_OFFSET_CAL: assert property (
    cal_in.done && !cal_in.is_gain
    |=> s.offset[$past(cal_in.setup)] == $past(cal_in.result))
    else $error("offset calibration not stored");
  AST_GAIN_CAL: assert property (
    cal_in.done && cal_in.is_gain && s.st == ascfr_pkg::ASCFR_ST_RUN
    |=> s.gain[$past(cal_in.setup)] == $past(cal_in.result))
    else $error("gain calibration not stored");
  AST_TRIM: assert property (
    $rose(rst_n) |=> s.gain[0] == $past(trim_gain_in) &&
                     s.gain[7] == $past(trim_gain_in))
    else $error("factory trim not loaded");
  AST_HOST_WR: assert property (
    wr_acc && idx == `ASCFR_IDX_OFFSET0 && pstrb_in[2:0] == 3'b111 &&
    !cal_in.done |=> s.offset[0] == $past(pwdata_in[23:0]))
    else $error("host offset write lost");
  AST_RSVD_BIT: assert property (
    psel_in && penable_in && kind_of(idx) == 2'h3
    |-> prdata_out[31:16] == 16'h0000 && prdata_out[11] == 1'b0)
    else $error("reserved filter bits read nonzero");
  // before the trim lands the gains hold the nominal unity value
  // but fout_out shows gain zero until the trim lands, then nominal for one cycle
  AST_GAIN_NOMINAL: assert property (
    $rose(rst_n) |-> s.gain[0] == `ASCFR_GAIN_NOMINAL &&
                     s.gain[7] == `ASCFR_GAIN_NOMINAL)
    else $error("gain not nominal before trim");
  // unmapped words must answer with an error, never silently
  AST_SLVERR: assert property (
    psel_in && penable_in && kind_of(idx) == 2'h0 |-> pslverr_out)
    else $error("unmapped word not refused");
  // mapped aligned words never raise an error
  AST_NO_SLVERR: assert property (
    psel_in && penable_in && kind_of(idx) != 2'h0 &&
    paddr_in[1:0] == 2'b00 |-> !pslverr_out)
    else $error("mapped word refused");
  // last offset word sits at the top index of its range
  AST_OFFSET7_WR: assert property (
    wr_acc && idx == `ASCFR_IDX_OFFSET7 && pstrb_in[2:0] == 3'b111 &&
    !cal_in.done |=> s.offset[7] == $past(pwdata_in[23:0]))
    else $error("offset word 7 misplaced");
  // first gain word belongs to setup 0; the trim cycle would win
  AST_GAIN0_WR: assert property (
    wr_acc && idx == `ASCFR_IDX_GAIN0 && pstrb_in[2:0] == 3'b111 &&
    !cal_in.done && s.st == ascfr_pkg::ASCFR_ST_RUN
    |=> s.gain[0] == $past(pwdata_in[23:0]))
    else $error("gain word 0 misplaced");
  // last gain word belongs to setup 7
  AST_GAIN7_WR: assert property (
    wr_acc && idx == `ASCFR_IDX_GAIN7 && pstrb_in[2:0] == 3'b111 &&
    !cal_in.done && s.st == ascfr_pkg::ASCFR_ST_RUN
    |=> s.gain[7] == $past(pwdata_in[23:0]))
    else $error("gain word 7 misplaced");
  // read data of the first offset word is that setup's value
  AST_RD_OFFSET0: assert property (
    setup_ph && idx == `ASCFR_IDX_OFFSET0 && paddr_in[1:0] == 2'b00
    |=> prdata_out == {8'h00, $past(s.offset[0])})
    else $error("offset word 0 read wrong");
  // read data of the last gain word is setup 7's value
  AST_RD_GAIN7: assert property (
    setup_ph && idx == `ASCFR_IDX_GAIN7 && paddr_in[1:0] == 2'b00
    |=> prdata_out == {8'h00, $past(s.gain[7])})
    else $error("gain word 7 read wrong");
  // a reserved filter code leaves the stored mode alone
  AST_RSVD_MODE: assert property (
    wr_acc && kind_of(idx) == 2'h3 &&
    pwdata_in[`ASCFR_MODE_HI:`ASCFR_MODE_LO] > `ASCFR_MODE_LAST
    |=> s.filt[$past(idx[2:0])].mode == $past(s.filt[idx[2:0]].mode))
    else $error("reserved filter code stored");
  // rate field takes the written value, zero included
  AST_RATE_WR: assert property (
    wr_acc && kind_of(idx) == 2'h3 && pstrb_in[1:0] == 2'b11
    |=> s.filt[$past(idx[2:0])].rate == $past(pwdata_in[10:0]))
    else $error("rate field write lost");

endmodule

// ---- tb/tb_top.sv ----
// self-checking testbench of the setup filter and calibration bank
`timescale 1ns/1ps
`include "ascfr_map.svh"
module tb_top;
  // clock, reset and apb master signals
  logic                   clk_in;
  logic                   reset_n_in;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [11:0]            paddr;
  logic [31:0]            pwdata;
  logic [3:0]             pstrb;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  // conversion core side
  logic [2:0]             active;
  ascfr_pkg::ascfr_cal_t  cal;
  logic [23:0]            trim;
  ascfr_pkg::ascfr_fout_t fout;
  // bench bookkeeping and register model
  int                     error_cnt;
  int                     checks_done;
  logic [31:0]            rdat;
  logic                   rerr;
  logic [3:0]             strb;
  logic [3:0]             fm [8];
  logic [10:0]            fr [8];
  logic [23:0]            om [8];
  logic [23:0]            gm [8];
  logic [9:0]             bad [4];
  logic [31:0]            d;
  logic [3:0]             m;
  logic [10:0]            r;

  ascfr_regs ascfr_regs_i (
    .clk_in          (clk_in),
    .reset_n_in      (reset_n_in),
    .psel_in         (psel),
    .penable_in      (penable),
    .pwrite_in       (pwrite),
    .paddr_in        (paddr),
    .pwdata_in       (pwdata),
    .pstrb_in        (pstrb),
    .prdata_out      (prdata),
    .pready_out      (pready),
    .pslverr_out     (pslverr),
    .active_setup_in (active),
    .cal_in          (cal),
    .trim_gain_in    (trim),
    .fout_out        (fout)
  );

  // free-running 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // compare, count and report at once
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // the single place where the run ends
  task automatic end_sim;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one apb transfer; waits for pready rather than assuming zero wait
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [31:0] wd);
    @(posedge clk_in);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    pstrb   <= strb;
    @(posedge clk_in);
    penable <= 1'b1;
    // no local limit: only the watchdog may end a stuck access
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // read a mapped word and compare with the model
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000);
    chk(rdat, exp);
    chk({pready, rerr}, 2'b10);
  endtask

  // expected filter word of one setup; reserved bits read zero
  function automatic logic [31:0] fword(input int s);
    return {16'h0000, fm[s], 1'b0, fr[s]};
  endfunction

  // expected steering for one setup, worked out from the mode table
  function automatic ascfr_pkg::ascfr_fout_t exp_fout(input int s);
    ascfr_pkg::ascfr_fout_t f;
    f.sinc4 = (fm[s] < 4'h2);
    f.averaging = (fm[s] == 4'h1) || (fm[s] == 4'h4);
    f.extra_notch_sixfifths = (fm[s] == 4'h3);
    f.post_filter = (fm[s] >= 4'h5) ? 3'(fm[s] - 4'h4) : 3'h0;
    f.fixed_rate = (fm[s] >= 4'h5);
    f.rate_divider_value = (fr[s] == 11'h000) ? 11'h001 : fr[s];
    f.offset = om[s];
    f.gain = gm[s];
    return f;
  endfunction

  // point the active setup and look at the steering once it follows
  task automatic fchk(input logic [2:0] s);
    @(posedge clk_in);
    active <= s;
    repeat (2) @(posedge clk_in);
    #1;
    chk(fout, exp_fout(s));
  endtask

  // one calibration result pulse from the conversion core
  task automatic calib(input logic g, input logic [2:0] s,
                       input logic [23:0] v);
    @(posedge clk_in);
    cal <= '{done: 1'b1, is_gain: g, setup: s, result: v};
    @(posedge clk_in);
    cal.done <= 1'b0;
    if (g) gm[s] = v;
    else om[s] = v;
  endtask

  // watchdog: the whole run needs under five hundred cycles
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end

  // main sequence
  initial begin
    error_cnt = 0;
    checks_done = 0;
    strb = 4'hF;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    active = 3'h0;
    cal = '0;
    reset_n_in = 1'b0;
    void'($urandom(32131));
    trim = 24'($urandom);
    bad = '{10'h028, 10'h039, 10'h03F, 10'h048};
    for (int i = 0; i < 8; i++) begin
      fm[i] = `ASCFR_MODE_RESET;
      fr[i] = `ASCFR_RATE_RESET;
      om[i] = `ASCFR_OFFSET_RESET;
      gm[i] = trim;
    end
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    // reset values of every word, gains after the trim load
    for (int i = 0; i < 8; i++) begin
      rd(`ASCFR_IDX_OFFSET0 + 10'(i), 32'(om[i]));
      rd(`ASCFR_IDX_GAIN0 + 10'(i), 32'(gm[i]));
      rd(`ASCFR_IDX_FILTER0 + 10'(i), fword(i));
    end
    fchk(3'h0);
    // random host writes of all coefficients, then read back
    for (int i = 0; i < 8; i++) begin
      om[i] = 24'($urandom);
      gm[i] = 24'($urandom);
      apb(1'b1, `ASCFR_IDX_OFFSET0 + 10'(i), {8'hFF, om[i]});
      apb(1'b1, `ASCFR_IDX_GAIN0 + 10'(i), {8'hFF, gm[i]});
    end
    // a write with one lane only merges that byte
    strb = 4'h2;
    d = $urandom;
    apb(1'b1, `ASCFR_IDX_OFFSET0 + 10'h005, d);
    om[5][15:8] = d[15:8];
    strb = 4'hF;
    for (int i = 0; i < 8; i++) begin
      rd(`ASCFR_IDX_OFFSET0 + 10'(i), 32'(om[i]));
      rd(`ASCFR_IDX_GAIN0 + 10'(i), 32'(gm[i]));
    end
    // unmapped words are refused and leave the bank alone
    foreach (bad[k]) begin
      apb(1'b1, bad[k], $urandom);
      chk(rerr, 1'b1);
      apb(1'b0, bad[k], 32'h00000000);
      chk({rerr, rdat}, {1'b1, 32'h00000000});
    end
    rd(`ASCFR_IDX_GAIN7, 32'(gm[7]));
    // every filter code, reserved ones refused; rate 0 and rate 48
    for (int k = 0; k < 16; k++) begin
      m = 4'(k);
      r = (k == 2) ? 11'h000 : (k == 3) ? 11'h030 : 11'($urandom);
      d = {16'($urandom), m, 1'b1, r};
      apb(1'b1, `ASCFR_IDX_FILTER0 + 10'(k % 8), d);
      if (m <= `ASCFR_MODE_LAST) fm[k % 8] = m;
      fr[k % 8] = r;
      rd(`ASCFR_IDX_FILTER0 + 10'(k % 8), fword(k % 8));
      fchk(3'(k % 8));
    end
    // calibration results land in the named setup's coefficient
    for (int k = 0; k < 8; k++) begin
      calib(k[0], 3'($urandom), 24'($urandom));
      calib(~k[0], 3'(k), 24'($urandom));
      fchk(3'(k));
      rd(`ASCFR_IDX_OFFSET0 + 10'(k), 32'(om[k]));
      rd(`ASCFR_IDX_GAIN0 + 10'(k), 32'(gm[k]));
    end
    end_sim();
  end
endmodule
